// file: design/ssi_encoder_end.sv
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - Idle: clock and data both rest high.
// - First falling edge after idle starts word.
// - Each of the first n rising edges outputs next bit, MSB first.
// - Turn count precedes angle within the word.
// - Controller gives n+1 rising edges per word.
// - Data held low for recovery after last rise.
// - Controller keeps clock high through recovery time.
// - Nominal serial clock rate is one megahertz.
// - Controller slows clock for long cables.
// - Up to three encoders share one clock.
// - Gray code steps change exactly one bit.
// - Default orientation: values rise clockwise.
// - Reverse option inverts Gray top bit.
// - BCD mode encodes each angle digit and the two low turn-count digits separately.
// - Programmable zero offset anywhere in range.
// - Data sent only in answer to clocks.
module ssi_encoder_end
    import ssi_pkg::*;
#(
    parameter int LANE = 0
)
(
    input  wire logic           sys_clk,
    input  wire logic           rst,
    ssi_link_if.encoder         link,
    input  wire logic [MT_BITS-1:0] turns,
    input  wire logic [ST_BITS-1:0] angle,
    input  wire logic [ST_BITS-1:0] zeroOffset,
    input  wire code_e          codeSel,
    input  wire logic           reverse,
    output logic                reading
);

    // ------------------------------------------------------------------
    // Encoder states
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        E_IDLE  = 3'b001,
        E_SEND  = 3'b010,
        E_RECOV = 3'b100
    } enc_state_e;

    localparam int SYNC_W = 4;
    localparam int S_CLK = 0;
    localparam int S_BIT = 1;
    localparam int S_DONE = 2;
    localparam int S_START = 3;

    enc_state_e          state;
    logic [WORD_BITS-1:0] liveWord;
    logic [WORD_BITS-1:0] heldWord;
    recov_t              recovCnt;
    logic                dataLine;
    logic                linkRst;

    logic [SYNC_W-1:0]   syncMeta;
    logic [SYNC_W-1:0]   syncStable;
    logic [SYNC_W-1:0]   syncPrev;
    logic                startEv;
    logic                doneEv;
    logic                recovDone;

    logic                startTgl;
    logic                doneTgl;
    logic                bitOut;
    bitcnt_t             bitCnt;
    logic [WORD_BITS-1:0] shiftReg;
    logic                frameOpen;

    // ------------------------------------------------------------------
    // Position coding
    // ------------------------------------------------------------------
    ssi_code_conv u_ssi_code_conv
    (
        .turns      (turns),
        .angle      (angle),
        .zeroOffset (zeroOffset),
        .codeSel    (codeSel),
        .reverse    (reverse),
        .word       (liveWord)
    );

    // ------------------------------------------------------------------
    // Link clock domain
    // ------------------------------------------------------------------
    // The link clock stands still outside frames, so this logic only
    // marks frame boundaries and shifts out the bits; the idle and recovery levels of the data
    // line belong to the system clock domain.
    assign frameOpen = startTgl != doneTgl;

    always_ff @(negedge link.ssiClk or posedge linkRst)
    begin
        if (linkRst)
            startTgl <= 1'b0;
        else if (!frameOpen)
            startTgl <= ~startTgl;
    end

    always_ff @(posedge link.ssiClk or posedge linkRst)
    begin
        if (linkRst)
        begin
            doneTgl  <= 1'b0;
            bitCnt   <= '0;
            bitOut   <= 1'b1;
            shiftReg <= '0;
        end
        else if (frameOpen)
        begin
            if (bitCnt == LAST_BIT)
            begin
                // The system side pulls the line low for recovery; the shifted
                // bit rests high so that the next start edge shows no stale bit.
                doneTgl <= ~doneTgl;
                bitCnt  <= '0;
                bitOut  <= 1'b1;
            end
            else if (bitCnt == '0)
            begin
                bitOut   <= heldWord[WORD_BITS-1];
                shiftReg <= heldWord << 1;
                bitCnt   <= bitCnt + bitcnt_t'(1);
            end
            else
            begin
                bitOut   <= shiftReg[WORD_BITS-1];
                shiftReg <= shiftReg << 1;
                bitCnt   <= bitCnt + bitcnt_t'(1);
            end
        end
    end

    // ------------------------------------------------------------------
    // Crossings into the system clock domain
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk)
    begin
        linkRst <= rst;
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            syncMeta   <= '0;
            syncStable <= '0;
            syncPrev   <= '0;
        end
        else
        begin
            syncMeta   <= {startTgl, doneTgl, bitOut, link.ssiClk};
            syncStable <= syncMeta;
            syncPrev   <= syncStable;
        end
    end

    assign startEv = syncStable[S_START] != syncPrev[S_START];
    assign doneEv = syncStable[S_DONE] != syncPrev[S_DONE];
    assign recovDone = recovCnt == RECOV_END;

    // ------------------------------------------------------------------
    // Frame sequencing and recovery monoflop
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk)
    begin
        if (rst)
            state <= E_IDLE;
        else
        begin
            unique case (state)
                E_IDLE:
                begin
                    if (startEv)
                        state <= E_SEND;
                end
                E_SEND:
                begin
                    if (doneEv)
                        state <= E_RECOV;
                end
                E_RECOV:
                begin
                    if (recovDone && syncStable[S_CLK])
                        state <= E_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
            recovCnt <= '0;
        else if (state != E_RECOV)
            recovCnt <= '0;
        else if (!recovDone)
            recovCnt <= recovCnt + recov_t'(1);
    end

    // ------------------------------------------------------------------
    // Position snapshot
    // ------------------------------------------------------------------
    // The word follows the position only while idle, so it is frozen from
    // the start edge until the recovery time has run out.
    always_ff @(posedge sys_clk)
    begin
        if (rst)
            heldWord <= '0;
        else if (state == E_IDLE && !startEv)
            heldWord <= liveWord;
    end

    // ------------------------------------------------------------------
    // Data line and status
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk)
    begin
        if (rst)
            dataLine <= 1'b1;
        else
        begin
            unique case (state)
                E_IDLE:  dataLine <= 1'b1;
                E_SEND:  dataLine <= doneEv ? 1'b0 : syncStable[S_BIT];
                E_RECOV: dataLine <= recovDone && syncStable[S_CLK];
            endcase
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
            reading <= 1'b0;
        else
            reading <= state != E_IDLE;
    end

    // Each encoder drives only its own data lane of the shared clock.
    assign link.encData[LANE] = dataLine;

endmodule
`default_nettype wire

// file: pkg/ssi_pkg.sv
`default_nettype none
package ssi_pkg;

    // ------------------------------------------------------------------
    // Clocking and link timing
    // ------------------------------------------------------------------
    localparam int CLK_HZ = 20_000_000;
    localparam int CLK_NS = 50;
    localparam int SSI_HZ = 1_000_000;
    localparam int HALF_CYC = CLK_HZ / (2 * SSI_HZ);
    localparam int RECOV_NS = 20_000;
    localparam int RECOV_CYC = (RECOV_NS + CLK_NS - 1) / CLK_NS;

    // ------------------------------------------------------------------
    // Word layout
    // ------------------------------------------------------------------
    localparam int ENC_COUNT = 3;
    localparam int MT_BITS = 8;
    localparam int ST_BITS = 13;
    localparam int ST_FIELD = 16;
    localparam int ST_PAD = ST_FIELD - ST_BITS;
    localparam int WORD_BITS = MT_BITS + ST_FIELD;
    localparam int BCD_W = 16;
    localparam int BCD_DIGIT = 4;

    typedef logic [4:0] bitcnt_t;
    typedef logic [7:0] phase_t;
    typedef logic [9:0] recov_t;

    localparam bitcnt_t LAST_BIT = bitcnt_t'(WORD_BITS);
    localparam bitcnt_t LAST_RISE = bitcnt_t'(WORD_BITS + 1);
    localparam phase_t HALF_END = phase_t'(HALF_CYC - 1);
    localparam recov_t RECOV_END = recov_t'(RECOV_CYC - 1);

    // ------------------------------------------------------------------
    // Output codes
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        CODE_BIN  = 2'h0,
        CODE_GRAY = 2'h1,
        CODE_BCD  = 2'h2
    } code_e;

endpackage
`default_nettype wire

// file: pkg/ssi_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface ssi_link_if;
    import ssi_pkg::*;

    logic                      ssiClk;
    wire logic [ENC_COUNT-1:0] encData;

    modport controller (output ssiClk, input encData);
    modport encoder (input ssiClk, output encData);
endinterface
`default_nettype wire

// file: design/ssi_code_conv.sv
`timescale 1ns/1ps
`default_nettype none
module ssi_code_conv
    import ssi_pkg::*;
(
    input  wire logic [MT_BITS-1:0]   turns,
    input  wire logic [ST_BITS-1:0]   angle,
    input  wire logic [ST_BITS-1:0]   zeroOffset,
    input  wire code_e                codeSel,
    input  wire logic                 reverse,
    output logic      [WORD_BITS-1:0] word
);

    // Double dabble: each decimal digit becomes its own nibble.
    function automatic logic [BCD_W-1:0] toBcd(input logic [BCD_W-1:0] val);
        logic [2*BCD_W-1:0] acc;
        int                 i;
        int                 d;
        acc = {{BCD_W{1'b0}}, val};
        for (i = 0; i < BCD_W; i++)
        begin
            for (d = 0; d < BCD_W / BCD_DIGIT; d++)
            begin
                if (acc[BCD_W + BCD_DIGIT*d +: BCD_DIGIT] > 4'h4)
                    acc[BCD_W + BCD_DIGIT*d +: BCD_DIGIT] = acc[BCD_W + BCD_DIGIT*d +: BCD_DIGIT] + 4'h3;
            end
            acc = acc << 1;
        end
        return acc[2*BCD_W-1:BCD_W];
    endfunction

    logic [ST_BITS-1:0] rel;
    logic [ST_BITS-1:0] dirRel;
    logic [ST_BITS-1:0] gray;
    logic [BCD_W-1:0]   bcdAngle;
    logic [BCD_W-1:0]   bcdTurns;

    assign rel = angle - zeroOffset;
    assign dirRel = reverse ? ST_BITS'(0) - rel : rel;
    assign gray = (rel ^ (rel >> 1)) ^ {reverse, {(ST_BITS-1){1'b0}}};
    assign bcdAngle = toBcd(BCD_W'(dirRel));
    assign bcdTurns = toBcd(BCD_W'(turns));

    always_comb
    begin
        unique case (codeSel)
            CODE_GRAY: word = {turns ^ (turns >> 1), {ST_PAD{1'b0}}, gray};
            CODE_BCD:  word = {bcdTurns[MT_BITS-1:0], bcdAngle};
            default:   word = {turns, {ST_PAD{1'b0}}, dirRel};
        endcase
    end

endmodule
`default_nettype wire

// file: design/ssi_controller_end.sv
`timescale 1ns/1ps
`default_nettype none
module ssi_controller_end
    import ssi_pkg::*;
(
    input  wire logic                                sys_clk,
    input  wire logic                                rst,
    ssi_link_if.controller                           link,
    input  wire logic                                startRead,
    output logic                                     busy,
    output logic                                     wordValid,
    output logic [ENC_COUNT-1:0][WORD_BITS-1:0]      position
);

    // ------------------------------------------------------------------
    // Controller states
    // ------------------------------------------------------------------
    typedef enum logic [3:0] {
        C_IDLE  = 4'b0001,
        C_LOW   = 4'b0010,
        C_HIGH  = 4'b0100,
        C_RECOV = 4'b1000
    } ctl_state_e;

    ctl_state_e                         state;
    phase_t                             phaseCnt;
    bitcnt_t                            riseCnt;
    recov_t                             recovCnt;
    logic                               sclk;
    logic [ENC_COUNT-1:0]               dataMeta;
    logic [ENC_COUNT-1:0]               dataStable;
    logic [ENC_COUNT-1:0][WORD_BITS-1:0] shiftIn;
    logic                               phaseEnd;
    logic                               sampleNow;
    logic                               wordDone;

    // The half period count is the single knob for a slower rate on long cables.
    assign phaseEnd = phaseCnt == HALF_END;
    assign sampleNow = state == C_HIGH && phaseEnd && riseCnt != LAST_RISE;
    assign wordDone = state == C_HIGH && phaseEnd && riseCnt == LAST_RISE;

    // ------------------------------------------------------------------
    // Clock generator
    // ------------------------------------------------------------------
    // The divider gives HALF_CYC system cycles per half period.
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            state    <= C_IDLE;
            phaseCnt <= '0;
            riseCnt  <= '0;
            recovCnt <= '0;
            sclk     <= 1'b1;
        end
        else
        begin
            unique case (state)
                C_IDLE:
                begin
                    sclk <= 1'b1;
                    if (startRead)
                    begin
                        state    <= C_LOW;
                        sclk     <= 1'b0;
                        phaseCnt <= '0;
                        riseCnt  <= '0;
                    end
                end
                C_LOW:
                begin
                    phaseCnt <= phaseEnd ? '0 : phaseCnt + phase_t'(1);
                    if (phaseEnd)
                    begin
                        state   <= C_HIGH;
                        sclk    <= 1'b1;
                        riseCnt <= riseCnt + bitcnt_t'(1);
                    end
                end
                C_HIGH:
                begin
                    phaseCnt <= phaseEnd ? '0 : phaseCnt + phase_t'(1);
                    if (wordDone)
                    begin
                        state    <= C_RECOV;
                        recovCnt <= '0;
                    end
                    else if (phaseEnd)
                    begin
                        state <= C_LOW;
                        sclk  <= 1'b0;
                    end
                end
                C_RECOV:
                begin
                    recovCnt <= recovCnt + recov_t'(1);
                    if (recovCnt == RECOV_END)
                        state <= C_IDLE;
                end
            endcase
        end
    end

    assign link.ssiClk = sclk;

    // ------------------------------------------------------------------
    // Data capture, one lane per encoder
    // ------------------------------------------------------------------
    // Bits are taken just before each falling edge, half a period after
    // the encoder moved them, which leaves room for the synchronisers.
    genvar lane;
    generate
        for (lane = 0; lane < ENC_COUNT; lane++)
        begin : g_lane
            always_ff @(posedge sys_clk)
            begin
                if (rst)
                begin
                    dataMeta[lane]   <= 1'b1;
                    dataStable[lane] <= 1'b1;
                    shiftIn[lane]    <= '0;
                    position[lane]   <= '0;
                end
                else
                begin
                    dataMeta[lane]   <= link.encData[lane];
                    dataStable[lane] <= dataMeta[lane];
                    if (sampleNow)
                        shiftIn[lane] <= {shiftIn[lane][WORD_BITS-2:0], dataStable[lane]};
                    if (wordDone)
                        position[lane] <= shiftIn[lane];
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------------
    // Status
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            busy      <= 1'b0;
            wordValid <= 1'b0;
        end
        else
        begin
            busy      <= state != C_IDLE || startRead;
            wordValid <= wordDone;
        end
    end

endmodule
`default_nettype wire

// file: tb/ssi_link_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module ssi_link_monitor
    import ssi_pkg::*;
(
    input wire logic                 sys_clk,
    input wire logic                 rst,
    input wire logic                 ssiClk,
    input wire logic [ENC_COUNT-1:0] encData
);
    logic       prevClk;
    logic [4:0] riseCnt;
    logic [9:0] hiCnt;
    logic [7:0] sinceRise;
    wire        rise = ssiClk && !prevClk;

    always_ff @(posedge sys_clk)
        if (rst)
            prevClk <= 1'b1;
        else
            prevClk <= ssiClk;

    // The rise count restarts on the falling edge that opens the next word.
    always_ff @(posedge sys_clk)
        if (rst)
            riseCnt <= 5'h00;
        else if (rise)
            riseCnt <= riseCnt + 5'h01;
        else if (!ssiClk && prevClk && riseCnt == 5'h19)
            riseCnt <= 5'h00;

    always_ff @(posedge sys_clk)
        if (rst || !ssiClk)
            hiCnt <= 10'h000;
        else if (hiCnt != 10'h3FF)
            hiCnt <= hiCnt + 10'h001;

    always_ff @(posedge sys_clk)
        if (rst || rise)
            sinceRise <= 8'h00;
        else if (sinceRise != 8'hFF)
            sinceRise <= sinceRise + 8'h01;

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);

    property p_clk_low;
        $fell(ssiClk) |=> !ssiClk [*8] ##1 !ssiClk ##1 ssiClk;
    endproperty
    a_clk_low: assert property (p_clk_low)
        else $error("clock low phase is not ten cycles");

    property p_clk_high;
        $rose(ssiClk) && riseCnt < 5'h18 |=> ssiClk [*8] ##1 ssiClk ##1 !ssiClk;
    endproperty
    a_clk_high: assert property (p_clk_high)
        else $error("clock high phase is not ten cycles");

    property p_rise_cnt;
        $rose(ssiClk) |-> riseCnt < 5'h19;
    endproperty
    a_rise_cnt: assert property (p_rise_cnt)
        else $error("more than 25 rising edges in one word");

    property p_recov_clk;
        $fell(ssiClk) && riseCnt == 5'h19 |-> hiCnt >= 10'(RECOV_CYC);
    endproperty
    a_recov_clk: assert property (p_recov_clk)
        else $error("clock fell before recovery ended");

    property p_recov_low;
        $rose(ssiClk) && riseCnt == 5'h18 |-> ##20 encData == '0 ##280 encData == '0;
    endproperty
    a_recov_low: assert property (p_recov_low)
        else $error("data not low during recovery");

    property p_idle_high;
        hiCnt > 10'h1A4 |-> &encData;
    endproperty
    a_idle_high: assert property (p_idle_high)
        else $error("data not high when idle");

    property p_idle_quiet;
        hiCnt > 10'h1A4 |=> $stable(encData);
    endproperty
    a_idle_quiet: assert property (p_idle_quiet)
        else $error("data moved without clock");

    property p_bit_timing;
        $changed(encData) && riseCnt != 5'h19 |-> sinceRise <= 8'h06;
    endproperty
    a_bit_timing: assert property (p_bit_timing)
        else $error("data changed away from a rising edge");

    c_frame: cover property ($rose(ssiClk) && riseCnt == 5'h18);
    c_next: cover property ($fell(ssiClk) && riseCnt == 5'h19);
    c_idle: cover property (hiCnt == 10'h1A5);
endmodule
`default_nettype wire

// file: tb/ssi_position_encoder_link_tb.sv
`timescale 1ns/1ps
`default_nettype none
module ssi_position_encoder_link_tb;
    import ssi_pkg::*;

    logic                                sys_clk = 1'b0;
    logic                                rst = 1'b1;
    logic                                startRead = 1'b0;
    logic                                busy;
    logic                                wordValid;
    logic [ENC_COUNT-1:0][WORD_BITS-1:0] position;
    logic [MT_BITS-1:0]                  turns [ENC_COUNT];
    logic [ST_BITS-1:0]                  angle [ENC_COUNT];
    logic [ST_BITS-1:0]                  zeroOff [ENC_COUNT];
    code_e                               codeSel [ENC_COUNT];
    logic                                reverse [ENC_COUNT];
    logic [WORD_BITS-1:0]                last [ENC_COUNT];
    wire logic [ENC_COUNT-1:0]           reading;
    int                                  error_cnt = 0;
    int                                  n_checks = 0;
    int                                  cyc = 0;

    ssi_link_if link ();

    ssi_controller_end u_ssi_controller_end (
        .sys_clk   (sys_clk),
        .rst       (rst),
        .link      (link),
        .startRead (startRead),
        .busy      (busy),
        .wordValid (wordValid),
        .position  (position)
    );

    for (genvar i = 0; i < ENC_COUNT; i++)
    begin : g_enc
        ssi_encoder_end #(.LANE(i)) u_ssi_encoder_end (
            .sys_clk    (sys_clk),
            .rst        (rst),
            .link       (link),
            .turns      (turns[i]),
            .angle      (angle[i]),
            .zeroOffset (zeroOff[i]),
            .codeSel    (codeSel[i]),
            .reverse    (reverse[i]),
            .reading    (reading[i])
        );
    end

    ssi_link_monitor u_ssi_link_monitor (
        .sys_clk (sys_clk),
        .rst     (rst),
        .ssiClk  (link.ssiClk),
        .encData (link.encData)
    );

    always #25 sys_clk = ~sys_clk;

    always @(posedge sys_clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            error_cnt++;
            $display("ERROR at %0t: timeout", $time);
            tally_and_finish();
        end
    end

    task automatic tally_and_finish();
        $display("checks %0d, mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic tick();
        @(posedge sys_clk);
        #1;
    endtask

    task automatic check(input logic [WORD_BITS-1:0] got, input logic [WORD_BITS-1:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic setLane(input int i, input logic [7:0] t, input logic [12:0] a, input logic [12:0] z,
                           input code_e c, input logic r);
        turns[i] = t;
        angle[i] = a;
        zeroOff[i] = z;
        codeSel[i] = c;
        reverse[i] = r;
    endtask

    function automatic logic [WORD_BITS-1:0] expWord(input logic [7:0] t, input logic [12:0] a,
                                                     input logic [12:0] z, input code_e c, input logic r);
        logic [12:0] rel;
        logic [12:0] v;
        int          n;
        rel = a - z;
        v = r ? 13'h0000 - rel : rel;
        n = int'(v);
        case (c)
            CODE_GRAY: return {t ^ (t >> 1), 3'h0, rel ^ (rel >> 1) ^ {r, 12'h000}};
            CODE_BCD: return {4'(t % 100 / 10), 4'(t % 10), 4'(n / 1000), 4'(n / 100 % 10),
                              4'(n / 10 % 10), 4'(n % 10)};
            default: return {t, 3'h0, v};
        endcase
    endfunction

    // One readout; the wire is sampled eight cycles after each of the first 24 rising edges and the word compared per lane.
    task automatic readCheck(input logic bump);
        logic [WORD_BITS-1:0] exp [ENC_COUNT];
        logic [WORD_BITS-1:0] got [ENC_COUNT];
        int                   n;
        for (int i = 0; i < ENC_COUNT; i++)
            exp[i] = expWord(turns[i], angle[i], zeroOff[i], codeSel[i], reverse[i]);
        startRead = 1'b1;
        tick();
        startRead = 1'b0;
        for (int k = 0; k < 25; k++)
        begin
            @(posedge link.ssiClk);
            if (k < 24)
            begin
                repeat (8) tick();
                for (int i = 0; i < ENC_COUNT; i++)
                    got[i][WORD_BITS-1-k] = link.encData[i];
                if (bump && k == 5)
                    angle[0] = angle[0] + 13'h0100;
            end
        end
        n = 0;
        while (wordValid !== 1'b1 && n < 40)
        begin
            tick();
            n++;
        end
        check(24'(wordValid), 24'h000001);
        check(24'(reading), 24'h000007);
        for (int i = 0; i < ENC_COUNT; i++)
        begin
            check(position[i], exp[i]);
            check(got[i], exp[i]);
            last[i] = position[i];
        end
        repeat (20) tick();
        check(24'(link.encData), 24'h000000);
        n = 0;
        while (busy !== 1'b0 && n < 600)
        begin
            tick();
            n++;
        end
        repeat (24) tick();
        check(24'({link.ssiClk, link.encData}), 24'h00000F);
        check(24'(reading), 24'h000000);
    endtask

    task automatic t_idle();
        repeat (40) tick();
        check(24'({link.ssiClk, link.encData}), 24'h00000F);
        check(24'({busy, wordValid}), 24'h000000);
        check(24'(reading), 24'h000000);
        $display("done: idle");
    endtask

    task automatic t_codes();
        for (int c = 0; c < 4; c++)
        begin
            setLane(0, 8'h93, 13'h04D2, 13'h0000, code_e'(c), 1'b0);
            setLane(1, 8'h63, 13'h0FFF, 13'h0123, code_e'(c), 1'b1);
            setLane(2, 8'hFF, 13'h1ABC, 13'h1FFF, code_e'(c), c[0]);
            readCheck(1'b0);
            if (c == 2)
                check(last[0], 24'h471234);
        end
        $display("done: codes");
    endtask

    task automatic t_steps();
        logic [WORD_BITS-1:0] p [ENC_COUNT];
        setLane(0, 8'h01, 13'h0FFF, 13'h0000, CODE_GRAY, 1'b0);
        setLane(1, 8'h01, 13'h0064, 13'h0000, CODE_BIN, 1'b0);
        setLane(2, 8'h01, 13'h0064, 13'h0000, CODE_BIN, 1'b1);
        readCheck(1'b0);
        for (int i = 0; i < ENC_COUNT; i++)
        begin
            p[i] = last[i];
            angle[i] = angle[i] + 13'h0001;
        end
        readCheck(1'b0);
        check(24'($countones(p[0] ^ last[0])), 24'h000001);
        check(last[1] - p[1], 24'h000001);
        check(p[2] - last[2], 24'h000001);
        $display("done: steps");
    endtask

    task automatic t_offset();
        setLane(0, 8'h12, 13'h0005, 13'h1FFF, CODE_BIN, 1'b0);
        readCheck(1'b0);
        check(last[0], 24'h120006);
        $display("done: offset");
    endtask

    task automatic t_snapshot();
        setLane(0, 8'h05, 13'h0200, 13'h0000, CODE_BIN, 1'b0);
        readCheck(1'b1);
        check(last[0], 24'h050200);
        readCheck(1'b0);
        check(last[0], 24'h050300);
        $display("done: snapshot");
    endtask

    initial
    begin
        for (int i = 0; i < ENC_COUNT; i++)
            setLane(i, 8'h00, 13'h0000, 13'h0000, CODE_BIN, 1'b0);
        repeat (6) tick();
        rst = 1'b0;
        repeat (3) tick();
        t_idle();
        t_codes();
        t_steps();
        t_offset();
        t_snapshot();
        tally_and_finish();
    end
endmodule
`default_nettype wire
